// >>> cdb_cfg_pkg.sv
package cdb_cfg_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CONFIG0_ADDR = 8'h60;
	localparam logic [7:0] RESEL_TOUT_ADDR = 8'h63;
	localparam logic [7:0] RSVD_64_ADDR = 8'h64;
	localparam logic [7:0] BUS_ID_ADDR = 8'h65;
	localparam logic [7:0] RSVD_66_ADDR = 8'h66;
	localparam logic [7:0] RSVD_67_ADDR = 8'h67;
	localparam logic [7:0] RSVD_68_ADDR = 8'h68;
	localparam logic [7:0] CMD_LEN_ADDR = 8'h69;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int LAYOUT_BIT = 5;
	localparam int SEL_ID_LSB = 5;
	localparam int SEL_INV_BIT = 4;
	localparam int OWN_ID_LSB = 0;
	localparam int RESEL_ID_LSB = 5;
	localparam int GROUP_LSB = 5;
	localparam int SUBGROUP_BIT = 4;
	localparam int G7_LSB = 6;
	localparam int G6_LSB = 4;
	localparam int G4_LSB = 2;
	localparam int G3_LSB = 0;
	localparam int G6D_LSB = 4;
	localparam int G6C_LSB = 2;
	localparam int G43_LSB = 0;
	localparam logic [7:0] RESEL_TOUT_RST = 8'h00;
	localparam logic [2:0] ID_RST = 3'h0;
	localparam logic [7:0] CMD_LEN_RST = 8'h00;
	localparam logic LAYOUT_RST = 1'b0;

	// ----------------------------------------
	// command lengths
	// ----------------------------------------
	localparam logic [3:0] LEN_UNDEF = 4'h0;
	localparam logic [3:0] LEN_6 = 4'h6;
	localparam logic [3:0] LEN_10 = 4'ha;
	localparam logic [3:0] LEN_12 = 4'hc;
	localparam logic [1:0] FIELD_6 = 2'h1;
	localparam logic [1:0] FIELD_10 = 2'h2;
	localparam logic [1:0] FIELD_12 = 2'h3;

	// ----------------------------------------
	// time-out scaling
	// ----------------------------------------
	// ms per unit is this figure over the clock rate in MHz
	localparam real TOUT_SCALE_MS_MHZ = 16.384;
	localparam real CLK_MHZ = 100.0;
	localparam int TOUT_UNIT_CYCLES =
		int'(TOUT_SCALE_MS_MHZ / CLK_MHZ * 1.0e-3 * CLK_MHZ * 1.0e6);
	localparam int UNIT_CNT_W = 24;

	typedef enum logic [0:0] {
		RESEL_IDLE = 1'b0,
		RESEL_WAIT = 1'b1
	} resel_state_e;
endpackage : cdb_cfg_pkg

// >>> cdb_len_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cdb_len_if;
	logic [7:0] opcode;
	logic layout;
	logic [7:0] size_reg;
	logic [3:0] byte_count;
	logic undefined;

	modport requester (
		output opcode,
		output layout,
		output size_reg,
		input byte_count,
		input undefined
	);
	modport decoder (
		input opcode,
		input layout,
		input size_reg,
		output byte_count,
		output undefined
	);
endinterface : cdb_len_if
`default_nettype wire

// >>> cdb_len_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cdb_len_decode (
	cdb_len_if.decoder lif
);
	logic [2:0] group;
	logic [1:0] field;
	logic fixed;
	logic [3:0] fixed_len;

	// ----------------------------------------
	// group code to length field
	// ----------------------------------------
	always_comb begin
		group = lif.opcode[cdb_cfg_pkg::GROUP_LSB +: 3];
		field = 2'h0;
		fixed = 1'b0;
		fixed_len = cdb_cfg_pkg::LEN_UNDEF;
		case (group)
		3'h0: begin
			fixed = 1'b1;
			fixed_len = cdb_cfg_pkg::LEN_6;
		end
		3'h1, 3'h2: begin
			fixed = 1'b1;
			fixed_len = cdb_cfg_pkg::LEN_10;
		end
		3'h5: begin
			fixed = 1'b1;
			fixed_len = cdb_cfg_pkg::LEN_12;
		end
		3'h3: begin
			// same bits in both layouts
			field = lif.size_reg[cdb_cfg_pkg::G3_LSB +: 2];
		end
		3'h4: begin
			if (lif.layout) begin
				field = lif.size_reg[cdb_cfg_pkg::G43_LSB +: 2];
			end else begin
				field = lif.size_reg[cdb_cfg_pkg::G4_LSB +: 2];
			end
		end
		3'h6: begin
			if (!lif.layout) begin
				field = lif.size_reg[cdb_cfg_pkg::G6_LSB +: 2];
			end else if (lif.opcode[cdb_cfg_pkg::SUBGROUP_BIT]) begin
				field = lif.size_reg[cdb_cfg_pkg::G6D_LSB +: 2];
			end else begin
				field = lif.size_reg[cdb_cfg_pkg::G6C_LSB +: 2];
			end
		end
		default: begin
			field = lif.size_reg[cdb_cfg_pkg::G7_LSB +: 2];
		end
		endcase
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	always_comb begin
		lif.undefined = 1'b0;
		if (fixed) begin
			lif.byte_count = fixed_len;
		end else begin
			case (field)
			cdb_cfg_pkg::FIELD_6: lif.byte_count = cdb_cfg_pkg::LEN_6;
			cdb_cfg_pkg::FIELD_10: lif.byte_count = cdb_cfg_pkg::LEN_10;
			cdb_cfg_pkg::FIELD_12: lif.byte_count = cdb_cfg_pkg::LEN_12;
			default: begin
				lif.byte_count = cdb_cfg_pkg::LEN_UNDEF;
				lif.undefined = 1'b1;
			end
			endcase
		end
	end
endmodule : cdb_len_decode
`default_nettype wire

// >>> scsi_target_id_cdb_config.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module scsi_target_id_cdb_config #(
	parameter int UNIT_CYCLES = cdb_cfg_pkg::TOUT_UNIT_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// selection from the sequencer
	input wire logic sel_respond,
	input wire logic [2:0] sel_initiator,
	input wire logic sel_single,
	// reselection from the sequencer
	input wire logic resel_start,
	input wire logic resel_answered,
	output logic resel_busy,
	output logic resel_failed,
	// command phase
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	output logic [3:0] cmd_bytes,
	output logic cmd_bytes_valid,
	output logic cmd_bytes_undef,
	// settings for the sequencer
	output logic [2:0] target_self_number,
	output logic [2:0] reselect_target_initiator
);
	typedef struct packed {
		logic [7:0] reselect_limit_value;
		logic length_layout_select;
		logic [2:0] selecting_initiator;
		logic selecting_initiator_invalid;
		logic [2:0] target_self_number;
		logic [2:0] reselect_target_initiator;
		logic [7:0] command_block_length;
		logic [7:0] rdata;
		cdb_cfg_pkg::resel_state_e resel_state;
		logic resel_failed;
		logic [cdb_cfg_pkg::UNIT_CNT_W-1:0] unit_cnt;
		logic [7:0] units_left;
		logic [3:0] cmd_bytes;
		logic cmd_bytes_valid;
		logic cmd_bytes_undef;
	} state_s;

	localparam logic [cdb_cfg_pkg::UNIT_CNT_W-1:0] UNIT_LAST =
		cdb_cfg_pkg::UNIT_CNT_W'(UNIT_CYCLES - 1);

	state_s st_r;
	state_s st_nxt;
	cdb_len_if lif ();

	assign lif.opcode = opcode;
	assign lif.layout = st_r.length_layout_select;
	assign lif.size_reg = st_r.command_block_length;

	cdb_len_decode u_decode (
		.lif(lif)
	);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.resel_failed = 1'b0;
		st_nxt.cmd_bytes_valid = 1'b0;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
			cdb_cfg_pkg::CONFIG0_ADDR: begin
				st_nxt.length_layout_select =
					reg_wdata[cdb_cfg_pkg::LAYOUT_BIT];
			end
			cdb_cfg_pkg::RESEL_TOUT_ADDR: begin
				st_nxt.reselect_limit_value = reg_wdata;
			end
			cdb_cfg_pkg::BUS_ID_ADDR: begin
				st_nxt.reselect_target_initiator =
					reg_wdata[cdb_cfg_pkg::RESEL_ID_LSB +: 3];
				st_nxt.target_self_number =
					reg_wdata[cdb_cfg_pkg::OWN_ID_LSB +: 3];
			end
			cdb_cfg_pkg::CMD_LEN_ADDR: begin
				st_nxt.command_block_length = reg_wdata;
			end
			default: begin
			end
			endcase
		end

		// register reads; unmapped and reserved read zero
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
			cdb_cfg_pkg::CONFIG0_ADDR: begin
				st_nxt.rdata[cdb_cfg_pkg::LAYOUT_BIT] =
					st_r.length_layout_select;
			end
			cdb_cfg_pkg::RESEL_TOUT_ADDR: begin
				st_nxt.rdata = st_r.reselect_limit_value;
			end
			cdb_cfg_pkg::BUS_ID_ADDR: begin
				st_nxt.rdata[cdb_cfg_pkg::SEL_ID_LSB +: 3] =
					st_r.selecting_initiator;
				st_nxt.rdata[cdb_cfg_pkg::SEL_INV_BIT] =
					st_r.selecting_initiator_invalid;
				st_nxt.rdata[cdb_cfg_pkg::OWN_ID_LSB +: 3] =
					st_r.target_self_number;
			end
			cdb_cfg_pkg::CMD_LEN_ADDR: begin
				st_nxt.rdata = st_r.command_block_length;
			end
			default: begin
			end
			endcase
		end

		// only a fresh selection replaces the capture; disconnect
		// leaves it alone
		if (sel_respond) begin
			st_nxt.selecting_initiator = sel_initiator;
			st_nxt.selecting_initiator_invalid = sel_single;
		end

		// ----------------------------------------
		// reselection time-out
		// ----------------------------------------
		case (st_r.resel_state)
		cdb_cfg_pkg::RESEL_IDLE: begin
			if (resel_start) begin
				st_nxt.resel_state = cdb_cfg_pkg::RESEL_WAIT;
				st_nxt.unit_cnt = '0;
				st_nxt.units_left = st_r.reselect_limit_value;
			end
		end
		cdb_cfg_pkg::RESEL_WAIT: begin
			// an answer in the expiry cycle still counts as success
			if (resel_answered) begin
				st_nxt.resel_state = cdb_cfg_pkg::RESEL_IDLE;
			end else if (st_r.units_left == 8'h00) begin
				st_nxt.resel_state = cdb_cfg_pkg::RESEL_IDLE;
				st_nxt.resel_failed = 1'b1;
			end else if (st_r.unit_cnt == UNIT_LAST) begin
				st_nxt.unit_cnt = '0;
				st_nxt.units_left = st_r.units_left - 8'h01;
			end else begin
				st_nxt.unit_cnt = st_r.unit_cnt +
					cdb_cfg_pkg::UNIT_CNT_W'(1);
			end
		end
		default: begin
			st_nxt.resel_state = cdb_cfg_pkg::RESEL_IDLE;
		end
		endcase

		// ----------------------------------------
		// command length capture
		// ----------------------------------------
		if (opcode_valid) begin
			st_nxt.cmd_bytes = lif.byte_count;
			st_nxt.cmd_bytes_undef = lif.undefined;
			st_nxt.cmd_bytes_valid = 1'b1;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_r <= '0;
			st_r.reselect_limit_value <= cdb_cfg_pkg::RESEL_TOUT_RST;
			st_r.length_layout_select <= cdb_cfg_pkg::LAYOUT_RST;
			st_r.target_self_number <= cdb_cfg_pkg::ID_RST;
			st_r.reselect_target_initiator <= cdb_cfg_pkg::ID_RST;
			st_r.command_block_length <= cdb_cfg_pkg::CMD_LEN_RST;
			st_r.resel_state <= cdb_cfg_pkg::RESEL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign resel_busy = (st_r.resel_state == cdb_cfg_pkg::RESEL_WAIT);
	assign resel_failed = st_r.resel_failed;
	assign cmd_bytes = st_r.cmd_bytes;
	assign cmd_bytes_valid = st_r.cmd_bytes_valid;
	assign cmd_bytes_undef = st_r.cmd_bytes_undef;
	assign target_self_number = st_r.target_self_number;
	assign reselect_target_initiator = st_r.reselect_target_initiator;
endmodule : scsi_target_id_cdb_config
`default_nettype wire

// >>> cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_props #(
	parameter int UNIT_CYCLES = cdb_cfg_pkg::TOUT_UNIT_CYCLES
) (
	// watched ports
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sel_respond,
	input wire logic [2:0] sel_initiator,
	input wire logic sel_single,
	input wire logic resel_start,
	input wire logic resel_answered,
	input wire logic resel_busy,
	input wire logic resel_failed,
	input wire logic opcode_valid,
	input wire logic [7:0] opcode,
	input wire logic [3:0] cmd_bytes,
	input wire logic cmd_bytes_valid,
	input wire logic cmd_bytes_undef,
	input wire logic [2:0] target_self_number,
	input wire logic [2:0] reselect_target_initiator
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic id_wr;
	logic id_rd;
	assign id_wr = reg_wr && reg_addr == cdb_cfg_pkg::BUS_ID_ADDR;
	assign id_rd = reg_rd && reg_addr == cdb_cfg_pkg::BUS_ID_ADDR;
	logic [2:0] wd_own;
	logic [2:0] wd_resel;
	assign wd_own = reg_wdata[2:0];
	assign wd_resel = reg_wdata[7:5];
	capture_id_a: assert property (sel_respond ##1 !sel_respond ##1 id_rd
		|=> reg_rdata[7:4] == {$past(sel_initiator, 3), $past(sel_single, 3)})
		else $error("captured initiator id not read back");
	own_id_rd_a: assert property (id_rd |=>
		reg_rdata[3:0] == {1'b0, target_self_number})
		else $error("own id not on read bits 2:0");
	own_id_wr_a: assert property (id_wr |=>
		target_self_number == $past(wd_own))
		else $error("own id write not taken");
	resel_id_wr_a: assert property (id_wr |=>
		reselect_target_initiator == $past(wd_resel))
		else $error("reselect id write not taken");
	id_hold_a: assert property (!id_wr |=> $stable(target_self_number))
		else $error("own id changed without write");
	short_len_a: assert property (opcode_valid && opcode[7:5] == 3'h0
		|=> cmd_bytes == 4'h6) else $error("group 0 length wrong");
	mid_len_a: assert property (opcode_valid
		&& (opcode[7:5] == 3'h1 || opcode[7:5] == 3'h2)
		|=> cmd_bytes == 4'ha) else $error("group 1/2 length wrong");
	long_len_a: assert property (opcode_valid && opcode[7:5] == 3'h5
		|=> cmd_bytes == 4'hc) else $error("group 5 length wrong");
	len_pulse_a: assert property (cmd_bytes_valid == $past(opcode_valid))
		else $error("length strobe misplaced");
	undef_flag_a: assert property (cmd_bytes_valid |->
		cmd_bytes_undef == (cmd_bytes == 4'h0))
		else $error("undefined flag disagrees with length");
	resel_go_a: assert property (resel_start && !resel_busy |=> resel_busy)
		else $error("reselection count did not start");
	fail_end_a: assert property (resel_failed |->
		!resel_busy && $past(resel_busy)) else $error("stray failure");
	answer_end_a: assert property (resel_busy && resel_answered
		|=> !resel_busy && !resel_failed) else $error("answer not honoured");
endmodule : cfg_props
bind scsi_target_id_cdb_config cfg_props #(.UNIT_CYCLES(UNIT_CYCLES)) i_props (
	.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.sel_respond, .sel_initiator, .sel_single,
	.resel_start, .resel_answered, .resel_busy, .resel_failed,
	.opcode_valid, .opcode, .cmd_bytes, .cmd_bytes_valid, .cmd_bytes_undef,
	.target_self_number, .reselect_target_initiator
);
`default_nettype wire

// >>> initiator_model.sv
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
	// clock and device state
	input wire logic mclk,
	input wire logic resel_busy,
	// selection and reply
	output logic sel_respond,
	output logic [2:0] sel_initiator,
	output logic sel_single,
	output logic resel_answered
);
	// 0: stays silent so the attempt must time out
	int reply_after = 0;
	int wait_cnt = 0;
	initial begin
		sel_respond = 1'b0;
		sel_initiator = 3'h0;
		sel_single = 1'b0;
		resel_answered = 1'b0;
	end
	always @(posedge mclk) begin
		wait_cnt <= resel_busy ? wait_cnt + 1 : 0;
		resel_answered <= resel_busy && reply_after != 0
			&& wait_cnt + 1 == reply_after;
	end
	task select(input logic [2:0] id, input logic single);
		@(posedge mclk);
		sel_respond <= 1'b1;
		sel_initiator <= id;
		sel_single <= single;
		@(posedge mclk);
		sel_respond <= 1'b0;
		// released id lines must not keep the captured value
		sel_initiator <= ~id;
		sel_single <= ~single;
	endtask : select
endmodule : initiator_model
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int UNIT = 4;
	logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, opcode = 0;
	logic resel_start = 0, opcode_valid = 0;
	wire logic [7:0] reg_rdata;
	wire logic [3:0] cmd_bytes;
	wire logic [2:0] sel_initiator, target_self_number, reselect_target_initiator;
	wire logic sel_respond, sel_single, resel_answered, resel_busy;
	wire logic resel_failed, cmd_bytes_valid, cmd_bytes_undef;
	int n_fail = 0, n_tests = 0, cyc;
	logic failed;
	always #5 mclk = ~mclk;
	scsi_target_id_cdb_config #(.UNIT_CYCLES(UNIT)) i_dut (.mclk, .rstn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sel_respond,
		.sel_initiator, .sel_single, .resel_start, .resel_answered,
		.resel_busy, .resel_failed, .opcode_valid, .opcode, .cmd_bytes,
		.cmd_bytes_valid, .cmd_bytes_undef, .target_self_number,
		.reselect_target_initiator);
	initiator_model i_init (.mclk, .resel_busy, .sel_respond, .sel_initiator,
		.sel_single, .resel_answered);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
	endtask : wr
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		#1 chk(reg_rdata, exp);
	endtask : rchk
	task t_regs;
		static logic [7:0] rsv [4] = '{8'h64, 8'h66, 8'h67, 8'h68};
		rchk(8'h63, 8'h00);
		rchk(8'h65, 8'h00);
		rchk(8'h69, 8'h00);
		foreach (rsv[i]) begin
			wr(rsv[i], 8'hff);
			rchk(rsv[i], 8'h00);
		end
		wr(8'h60, 8'hff);
		rchk(8'h60, 8'h20);
		wr(8'h63, 8'ha5);
		rchk(8'h63, 8'ha5);
		wr(8'h69, 8'h3c);
		rchk(8'h69, 8'h3c);
	endtask : t_regs
	task t_ids;
		wr(8'h65, 8'ha3);
		rchk(8'h65, 8'h03);
		chk(target_self_number, 3);
		chk(reselect_target_initiator, 5);
		i_init.select(3'h6, 1'b0);
		rchk(8'h65, 8'hc3);
		i_init.select(3'h2, 1'b1);
		rchk(8'h65, 8'h53);
		wr(8'h65, 8'h01);
		rchk(8'h65, 8'h51);
		chk(reselect_target_initiator, 0);
	endtask : t_ids
	function logic [3:0] exp_len(logic lay, logic [7:0] sz, logic [7:0] op);
		logic [1:0] f;
		case (op[7:5])
			3'h0: return 4'h6;
			3'h1, 3'h2: return 4'ha;
			3'h5: return 4'hc;
			3'h3: f = sz[1:0];
			3'h4: f = lay ? sz[1:0] : sz[3:2];
			3'h6: f = (lay && !op[4]) ? sz[3:2] : sz[5:4];
			default: f = sz[7:6];
		endcase
		return f == 0 ? 4'h0 : f == 1 ? 4'h6 : f == 2 ? 4'ha : 4'hc;
	endfunction : exp_len
	task t_len;
		static logic [7:0] sz [4] = '{8'he4, 8'h1b, 8'h4e, 8'hb1};
		static logic [7:0] ops [9] = '{8'h08, 8'h28, 8'h4a, 8'ha8, 8'h60,
			8'h80, 8'hc0, 8'hd0, 8'he0};
		for (int l = 0; l < 2; l++) foreach (sz[s]) begin
			wr(8'h60, l ? 8'h20 : 8'h00);
			wr(8'h69, sz[s]);
			foreach (ops[o]) begin
				@(posedge mclk);
				opcode_valid <= 1;
				opcode <= ops[o];
				@(posedge mclk);
				opcode_valid <= 0;
				#1 chk(cmd_bytes_valid, 1);
				chk(cmd_bytes, exp_len(l, sz[s], ops[o]));
				chk(cmd_bytes_undef, exp_len(l, sz[s], ops[o]) == 0);
			end
		end
	endtask : t_len
	task resel_run(input logic [7:0] n);
		wr(8'h63, n);
		@(posedge mclk);
		resel_start <= 1;
		@(posedge mclk);
		resel_start <= 0;
		#1 chk(resel_busy, 1);
		cyc = 1;
		failed = 0;
		do begin
			@(posedge mclk);
			#1 cyc++;
			failed |= resel_failed;
		end while (resel_busy && cyc < 2000);
	endtask : resel_run
	task t_resel;
		resel_run(8'h02);
		chk(failed, 1);
		chk(cyc, 1 + 2 * UNIT + 1);
		resel_run(8'h00);
		chk(cyc, 2);
		i_init.reply_after = 3;
		resel_run(8'h03);
		chk(failed, 0);
		chk(cyc < 1 + 3 * UNIT + 1, 1);
		i_init.reply_after = 0;
	endtask : t_resel
	task end_of_test;
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1;
		t_regs();
		t_ids();
		t_len();
		t_resel();
		end_of_test();
	end
	// whole run is a few hundred cycles
	initial begin
		#200us;
		n_fail++;
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
